/* design/twcps_bus_if.sv */
// interface joining master and slave over the two open-drain lines
`timescale 1ns/10ps
interface twcps_bus_if;
    logic m_scl_out;
    logic m_scl_oe;
    logic m_sda_out;
    logic m_sda_oe;
    logic s_sda_out;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // pull-ups win whenever nobody drives low
    assign scl = m_scl_oe ? m_scl_out : 1'b1;
    assign sda = (m_sda_oe ? m_sda_out : 1'b1) & (s_sda_oe ? s_sda_out : 1'b1);

    modport master (
        output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe,
        input  scl, sda
    );
    modport slave (
        output s_sda_out, s_sda_oe,
        input  scl, sda
    );
endinterface

/* design/twcps_master.sv */
// host end: byte-level two-wire master that makes scl from its own clock
`timescale 1ns/10ps
module twcps_master
    import twcps_pkg::*;
#(
    parameter int QUARTER_CYC = TWCPS_QUARTER_CYC
)(
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    // bus lines
    twcps_bus_if.master        bus,
    // command port
    input  wire logic          cmd_valid_in,
    input  wire twcps_cmd_type cmd_in,
    input  wire logic [7:0]    wdata_in,
    input  wire logic          ack_in,
    output logic               cmd_ready_out,
    // result
    output logic               done_out,
    output logic [7:0]         rdata_out,
    output logic               nack_out
);
    localparam int QW = $clog2(QUARTER_CYC + 1);
    localparam logic [QW-1:0] Q_END = QW'(QUARTER_CYC - 1);

    twcps_mst_state_type state_r;
    twcps_cmd_type       cmd_r;

    logic          sda_meta_r;
    logic          sda_sync_r;
    logic [QW-1:0] qcnt_r;
    logic [1:0]    phase_r;
    logic [3:0]    slot_r;
    logic [7:0]    shift_r;
    logic          ack_r;
    logic          samp_r;
    logic          scl_oe_r;
    logic          sda_oe_r;
    logic          done_r;
    logic [7:0]    rdata_r;
    logic          nack_r;
    logic          tick;
    logic          accept;
    logic          is_start;
    logic          bit_lvl;

    // sda comes back from the slave on another clock
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sda_meta_r <= 1'b1;
            sda_sync_r <= 1'b1;
        end else begin
            sda_meta_r <= bus.sda;
            sda_sync_r <= sda_meta_r;
        end
    end

    assign accept   = (state_r == TM_IDLE) & cmd_valid_in;
    assign tick     = (state_r != TM_IDLE) & (qcnt_r == Q_END);
    assign is_start = (cmd_r == TWCPS_CMD_START);

    // level for the current data slot; released where the slave talks
    always_comb begin
        if (slot_r == TWCPS_SLOT_ACK) begin
            bit_lvl = (cmd_r == TWCPS_CMD_READ) ? ~ack_r : 1'b1;
        end else begin
            bit_lvl = (cmd_r == TWCPS_CMD_WRITE) ? shift_r[7] : 1'b1;
        end
    end

    // quarter-period divider
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            qcnt_r <= '0;
        end else if (state_r == TM_IDLE || tick) begin
            qcnt_r <= '0;
        end else begin
            qcnt_r <= qcnt_r + 1'b1;
        end
    end

    // start and stop take one scl period, a byte command nine: drop, set sda, raise, then set sda again for start and stop, sample for a byte
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r  <= TM_IDLE;
            cmd_r    <= TWCPS_CMD_STOP;
            phase_r  <= TWCPS_Q_LOW0;
            slot_r   <= 4'h0;
            shift_r  <= 8'hff;
            ack_r    <= 1'b0;
            samp_r   <= 1'b1;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (accept) begin
            cmd_r    <= cmd_in;
            ack_r    <= ack_in;
            shift_r  <= (cmd_in == TWCPS_CMD_WRITE) ? wdata_in : 8'hff;
            slot_r   <= 4'h0;
            phase_r  <= TWCPS_Q_LOW0;
            scl_oe_r <= 1'b1;
            state_r  <= (cmd_in == TWCPS_CMD_START || cmd_in == TWCPS_CMD_STOP) ?
                        TM_COND : TM_BYTE;
        end else if (tick) begin
            phase_r <= phase_r + 2'h1;
            unique case (phase_r)
                TWCPS_Q_LOW0: begin
                    sda_oe_r <= (state_r == TM_COND) ? ~is_start : ~bit_lvl;
                end
                TWCPS_Q_LOW1: begin
                    scl_oe_r <= 1'b0; // released, pull-up raises it
                end
                TWCPS_Q_HIGH0: begin
                    samp_r <= sda_sync_r;
                    if (state_r == TM_COND) begin
                        sda_oe_r <= is_start;
                    end
                end
                TWCPS_Q_HIGH1: begin
                    if (state_r == TM_BYTE && slot_r != TWCPS_SLOT_ACK) begin
                        shift_r  <= {shift_r[6:0], samp_r};
                        slot_r   <= slot_r + 4'h1;
                        scl_oe_r <= 1'b1;
                    end else begin
                        state_r <= TM_IDLE; // scl stays high until next command
                    end
                end
                default: begin
                    state_r <= TM_IDLE;
                end
            endcase
        end
    end

    // results appear with the done pulse
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_r  <= 1'b0;
            rdata_r <= 8'h00;
            nack_r  <= 1'b0;
        end else begin
            done_r <= tick & (phase_r == TWCPS_Q_HIGH1) &
                      ((state_r == TM_COND) | (slot_r == TWCPS_SLOT_ACK));
            if (tick && phase_r == TWCPS_Q_HIGH1 && state_r == TM_BYTE &&
                slot_r == TWCPS_SLOT_ACK) begin
                rdata_r <= shift_r;
                nack_r  <= (cmd_r == TWCPS_CMD_WRITE) & samp_r;
            end
        end
    end

    assign bus.m_scl_out = 1'b0;
    assign bus.m_scl_oe  = scl_oe_r;
    assign bus.m_sda_out = 1'b0;
    assign bus.m_sda_oe  = sda_oe_r;

    assign cmd_ready_out = (state_r == TM_IDLE);
    assign done_out      = done_r;
    assign rdata_out     = rdata_r;
    assign nack_out      = nack_r;
endmodule

/* design/twcps_pin_filter.sv */
// two-flop synchroniser followed by a stability filter, one per bit
`timescale 1ns/10ps
module twcps_pin_filter
    import twcps_pkg::*;
#(
    parameter int               WIDTH    = 2,
    parameter int               FILT_LEN = TWCPS_FILT_LEN,
    parameter logic [WIDTH-1:0] RST_VAL  = '1
)(
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    // raw pins and cleaned levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] filt_out
);
    localparam int CW = $clog2(FILT_LEN + 1);
    localparam logic [CW-1:0] CNT_END = CW'(FILT_LEN - 1);

    genvar g;
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
        logic          meta_r;
        logic          sync_r;
        logic          filt_r;
        logic [CW-1:0] cnt_r;

        // first flop feeds only the second
        always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                meta_r <= RST_VAL[g];
                sync_r <= RST_VAL[g];
            end else begin
                meta_r <= pin_in[g];
                sync_r <= meta_r;
            end
        end

        // a new level must hold for the whole filter length to pass
        always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                filt_r <= RST_VAL[g];
                cnt_r  <= '0;
            end else if (sync_r == filt_r) begin
                cnt_r <= '0;
            end else if (cnt_r == CNT_END) begin
                filt_r <= sync_r;
                cnt_r  <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end

        assign filt_out[g] = filt_r;
    end
endmodule

/* design/twcps_pkg.sv */
// constants and types shared by both ends of the two-wire control port
// What this block does
// - device is slave only, master controls
// - sda changes only while scl low
// - sda falling with scl high starts transfer
// - first byte: seven-bit address plus direction
// - address 10011 plus two select pins
// - ack on ninth pulse only on match
// - every byte travels msb first
// - withheld write ack leaves sda high
// - master nack ends read data
// - first written byte is register base address
// - write pointer increments, saturates at 14h
// - base address above 14h gets no ack
// - read starts at stored base address
// - read pointer increments after each acked byte, saturates at 14h
// - sda rising with scl high stops transfer
// - repeated start accepted without stop
// - lines idle high, only pulled low
// - master read sequence: write base, restart, read
package twcps_pkg;

    // slave address layout
    localparam logic [4:0] TWCPS_ADDR_HI   = 5'h13;
    localparam int         TWCPS_SEL_W     = 2;
    localparam logic [7:0] TWCPS_REG_TOP   = 8'h14;

    // bit slots within a byte, the ninth slot carries the acknowledge
    localparam logic [3:0] TWCPS_SLOT_LAST = 4'h7;
    localparam logic [3:0] TWCPS_SLOT_ACK  = 4'h8;

    // pin filter length in link clock cycles
    localparam int         TWCPS_FILT_LEN  = 3;

    // master timing: scl period is four equal quarters
    localparam int         TWCPS_CLK_PERIOD_NS = 50;
    localparam int         TWCPS_SCL_PERIOD_NS = 10000;
    localparam int         TWCPS_QUARTER_CYC   =
        (TWCPS_SCL_PERIOD_NS / 4) / TWCPS_CLK_PERIOD_NS;

    // quarter phases of one scl period
    localparam logic [1:0] TWCPS_Q_LOW0  = 2'h0;
    localparam logic [1:0] TWCPS_Q_LOW1  = 2'h1;
    localparam logic [1:0] TWCPS_Q_HIGH0 = 2'h2;
    localparam logic [1:0] TWCPS_Q_HIGH1 = 2'h3;

    // master byte-level commands
    typedef enum logic [1:0] {
        TWCPS_CMD_START = 2'h0,
        TWCPS_CMD_STOP  = 2'h1,
        TWCPS_CMD_WRITE = 2'h2,
        TWCPS_CMD_READ  = 2'h3
    } twcps_cmd_type;

    // slave states
    typedef enum logic [5:0] {
        TS_IDLE   = 6'h01,
        TS_ADDR   = 6'h02,
        TS_REGA   = 6'h04,
        TS_WDATA  = 6'h08,
        TS_RDATA  = 6'h10,
        TS_IGNORE = 6'h20
    } twcps_slv_state_type;

    // master states
    typedef enum logic [2:0] {
        TM_IDLE = 3'h1,
        TM_COND = 3'h2,
        TM_BYTE = 3'h4
    } twcps_mst_state_type;

endpackage

/* design/twcps_slave.sv */
// device end: register access slave on the two-wire bus, link clock domain
`timescale 1ns/10ps
module twcps_slave
    import twcps_pkg::*;
(
    // link clock and reset
    input  wire logic                   link_clk_in,
    input  wire logic                   rst_b_in,
    // bus lines
    twcps_bus_if.slave                  bus,
    // address select pins
    input  wire logic [TWCPS_SEL_W-1:0] address_select_pins_in,
    // register write port
    output logic                        wr_en_out,
    output logic      [7:0]             wr_addr_out,
    output logic      [7:0]             wr_data_out,
    // register read port, data answered combinationally in this domain
    output logic      [7:0]             rd_addr_out,
    input  wire logic [7:0]             rd_data_in,
    // status
    output logic                        selected_out
);
    twcps_slv_state_type state_r;

    logic [TWCPS_SEL_W-1:0] sel_f;
    logic                   scl_f;
    logic                   sda_f;
    logic                   scl_p_r;
    logic                   sda_p_r;
    logic [3:0]             slot_r;
    logic [7:0]             shift_r;
    logic                   sda_oe_r;
    logic                   rw_r;
    logic                   mack_r;
    logic [7:0]             base_r;
    logic [7:0]             ptr_r;
    logic                   wr_en_r;
    logic [7:0]             wr_addr_r;
    logic [7:0]             wr_data_r;

    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic byte_end;
    logic ack_end;
    logic addr_match;
    logic rega_ok;
    logic wdata_end;
    logic rd_next;
    logic rd_first;

    // pins and straps pass two flops and a filter before anything looks
    twcps_pin_filter #(
        .WIDTH    (TWCPS_SEL_W + 2),
        .FILT_LEN (TWCPS_FILT_LEN),
        .RST_VAL  ({{TWCPS_SEL_W{1'b0}}, 2'b11})
    ) u_filt (
        .clk_in   (link_clk_in),
        .rst_b_in (rst_b_in),
        .pin_in   ({address_select_pins_in, bus.scl, bus.sda}),
        .filt_out ({sel_f, scl_f, sda_f})
    );

    // previous cleaned levels for edge and condition detection
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
        end else begin
            scl_p_r <= scl_f;
            sda_p_r <= sda_f;
        end
    end

    // sda moving while scl stays high is a condition, never data
    assign start_det = scl_f & scl_p_r & sda_p_r & ~sda_f;
    assign stop_det  = scl_f & scl_p_r & ~sda_p_r & sda_f;
    assign scl_rise  = scl_f & ~scl_p_r;
    assign scl_fall  = ~scl_f & scl_p_r;
    assign byte_end  = scl_fall & (slot_r == TWCPS_SLOT_LAST);
    assign ack_end   = scl_fall & (slot_r == TWCPS_SLOT_ACK);

    // byte-level decisions
    assign addr_match = (shift_r[7:1] == {TWCPS_ADDR_HI, sel_f});
    assign rega_ok    = (shift_r <= TWCPS_REG_TOP);
    assign wdata_end  = (state_r == TS_WDATA) & byte_end & ~start_det & ~stop_det;
    assign rd_first   = (state_r == TS_ADDR) & byte_end & addr_match & shift_r[0];
    assign rd_next    = (state_r == TS_RDATA) & scl_rise & (slot_r == TWCPS_SLOT_ACK) & ~sda_f;

    // main sequencer: conditions override whatever state is current
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r  <= TS_IDLE;
            slot_r   <= 4'h0;
            shift_r  <= 8'h00;
            sda_oe_r <= 1'b0;
            rw_r     <= 1'b0;
            mack_r   <= 1'b0;
        end else if (start_det) begin
            state_r  <= TS_ADDR;
            slot_r   <= 4'hf; // scl is still high: the next fall only opens bit 0
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            state_r  <= TS_IDLE;
            slot_r   <= 4'h0;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (state_r)
                TS_IDLE, TS_IGNORE: begin
                    sda_oe_r <= 1'b0;
                end
                TS_ADDR, TS_REGA, TS_WDATA: begin
                    if (scl_rise && slot_r != TWCPS_SLOT_ACK) begin
                        shift_r <= {shift_r[6:0], sda_f};
                    end
                    if (byte_end) begin
                        slot_r <= TWCPS_SLOT_ACK;
                        if (state_r == TS_ADDR) begin
                            rw_r <= shift_r[0];
                            if (addr_match) begin
                                sda_oe_r <= 1'b1;
                            end else begin
                                state_r <= TS_IGNORE;
                            end
                        end else if (state_r == TS_REGA && !rega_ok) begin
                            state_r <= TS_IGNORE;
                        end else begin
                            sda_oe_r <= 1'b1;
                        end
                    end else if (ack_end) begin
                        slot_r <= 4'h0;
                        if (state_r == TS_ADDR && rw_r) begin
                            state_r  <= TS_RDATA;
                            shift_r  <= rd_data_in;
                            sda_oe_r <= ~rd_data_in[7];
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r  <= (state_r == TS_ADDR) ? TS_REGA : TS_WDATA;
                        end
                    end else if (scl_fall) begin
                        slot_r <= slot_r + 4'h1;
                    end
                end
                TS_RDATA: begin
                    if (scl_rise && slot_r == TWCPS_SLOT_ACK) begin
                        mack_r <= ~sda_f;
                    end
                    if (byte_end) begin
                        slot_r   <= TWCPS_SLOT_ACK;
                        sda_oe_r <= 1'b0; // master owns the ack slot
                    end else if (ack_end) begin
                        slot_r <= 4'h0;
                        if (mack_r) begin
                            shift_r  <= rd_data_in;
                            sda_oe_r <= ~rd_data_in[7];
                        end else begin
                            state_r <= TS_IGNORE;
                        end
                    end else if (scl_fall) begin
                        slot_r   <= slot_r + 4'h1;
                        shift_r  <= {shift_r[6:0], 1'b0};
                        sda_oe_r <= ~shift_r[6]; // changes only after scl falls
                    end
                end
                default: begin
                    state_r  <= TS_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // base address and running pointer; a base above the top register is not stored, the pointer clamps there
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            base_r <= 8'h00;
            ptr_r  <= 8'h00;
        end else if (state_r == TS_REGA && byte_end && !start_det && !stop_det && rega_ok) begin
            base_r <= shift_r;
            ptr_r  <= shift_r;
        end else if (rd_first && !start_det && !stop_det) begin
            ptr_r <= base_r;
        end else if ((wdata_end || rd_next) && ptr_r < TWCPS_REG_TOP) begin
            ptr_r <= ptr_r + 8'h01;
        end
    end

    // one-cycle write strobe, pointer taken before it advances
    always_ff @(posedge link_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_en_r   <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            wr_en_r <= wdata_end;
            if (wdata_end) begin
                wr_addr_r <= ptr_r;
                wr_data_r <= shift_r;
            end
        end
    end

    // open drain: only ever pull low, never push high, never hold scl
    assign bus.s_sda_out = 1'b0;
    assign bus.s_sda_oe  = sda_oe_r;

    assign wr_en_out    = wr_en_r;
    assign wr_addr_out  = wr_addr_r;
    assign wr_data_out  = wr_data_r;
    assign rd_addr_out  = ptr_r;
    assign selected_out = (state_r == TS_REGA) | (state_r == TS_WDATA) | (state_r == TS_RDATA);
endmodule

/* testbench/tb.sv */
// self-checking bench: master and slave ends joined over the two-wire lines
`timescale 1ns/10ps
module tb;
    import twcps_pkg::*;

    localparam int         QC  = 8;
    localparam logic [1:0] SEL = 2'h2;
    localparam logic [7:0] SLV = {TWCPS_ADDR_HI, SEL, 1'b0};

    typedef struct {
        int         kind;
        logic [7:0] val;
    } twcps_note_type;

    logic           clk_in, link_clk_in, rst_b_in, cmd_valid, ack, ready, done, nack;
    logic           wr_en, selected;
    twcps_cmd_type  cmd_c;
    logic [7:0]     wdata, rdata, wr_addr, wr_data, rd_addr, rd_data;
    logic [7:0]     regs [0:31];
    logic [7:0]     shadow [0:31];
    twcps_note_type nq[$];
    twcps_note_type nt;
    logic [15:0]    wq[$];
    int             mismatches, checks_done, cycles;
    integer         seed = 32'h46bc;

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    // link clock offset so the two clocks keep no phase relation
    initial begin
        link_clk_in = 1'b0;
        #7;
        forever #24 link_clk_in = ~link_clk_in;
    end

    twcps_bus_if bus ();
    twcps_master #(.QUARTER_CYC(QC)) twcps_master_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .bus(bus), .cmd_valid_in(cmd_valid), .cmd_in(cmd_c), .wdata_in(wdata), .ack_in(ack),
        .cmd_ready_out(ready), .done_out(done), .rdata_out(rdata), .nack_out(nack));
    twcps_slave twcps_slave_inst (.link_clk_in(link_clk_in), .rst_b_in(rst_b_in), .bus(bus),
        .address_select_pins_in(SEL), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
        .wr_data_out(wr_data), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
        .selected_out(selected));
    twcps_checker #(.SEL(SEL)) twcps_checker_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .link_clk_in(link_clk_in), .link_rst_b_in(rst_b_in), .m_scl_out(bus.m_scl_out),
        .m_scl_oe(bus.m_scl_oe), .m_sda_out(bus.m_sda_out), .m_sda_oe(bus.m_sda_oe),
        .s_sda_out(bus.s_sda_out), .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // register file on the link side; each strobe meets the oldest expected write
    assign rd_data = regs[rd_addr[4:0]];
    always @(negedge link_clk_in) begin
        if (wr_en === 1'b1) begin
            regs[wr_addr[4:0]] <= wr_data;
            check({wr_addr, wr_data}, wq.size() > 0 ? wq.pop_front() : 16'hxxxx);
        end
    end

    // result watcher: every done pops one note
    always @(negedge clk_in) begin
        if (done === 1'b1) begin
            if (nq.size() > 0) nt = nq.pop_front(); else nt = '{1, 8'hxx};
            if (nt.kind == 1) check({15'h0000, nack}, {8'h00, nt.val});
            if (nt.kind == 2) check({8'h00, rdata}, {8'h00, nt.val});
        end
    end

    // hang guard, roughly four and a half times the expected run
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            stop_test();
        end
    end

    // one command, held until taken, then wait for its done
    task automatic cmd(input twcps_cmd_type c, input logic [7:0] d, input logic a,
                       input int kind, input logic [7:0] v);
        nq.push_back('{kind, v});
        @(negedge clk_in);
        cmd_c = c;
        wdata = d;
        ack = a;
        cmd_valid = 1'b1;
        while (ready !== 1'b1) @(negedge clk_in);
        @(negedge clk_in);
        cmd_valid = 1'b0;
        do @(negedge clk_in); while (done !== 1'b1);
    endtask

    // write frame; refused address or base sends no strobe
    task automatic wr_seq(input logic [7:0] sl, input logic [7:0] base, input int nb);
        logic       ok;
        logic [7:0] p, d;
        ok = sl[7:1] == SLV[7:1];
        cmd(TWCPS_CMD_START, 8'h00, 1'b0, 0, 8'h00);
        cmd(TWCPS_CMD_WRITE, sl, 1'b0, 1, {7'h00, !ok});
        if (ok && !sl[0]) begin
            ok = base <= TWCPS_REG_TOP;
            cmd(TWCPS_CMD_WRITE, base, 1'b0, 1, {7'h00, !ok});
            p = base;
            for (int i = 0; i < nb; i++) begin
                d = 8'($random(seed));
                if (ok) wq.push_back({p, d});
                if (ok) shadow[p[4:0]] = d;
                cmd(TWCPS_CMD_WRITE, d, 1'b0, 1, {7'h00, !ok});
                if (p < TWCPS_REG_TOP) p++;
            end
        end
        cmd(TWCPS_CMD_STOP, 8'h00, 1'b0, 0, 8'h00);
    endtask

    // base write, repeated start, reads; last byte not acknowledged
    task automatic rd_seq(input logic [7:0] base, input int nb);
        logic [7:0] p;
        p = base;
        cmd(TWCPS_CMD_START, 8'h00, 1'b0, 0, 8'h00);
        cmd(TWCPS_CMD_WRITE, SLV, 1'b0, 1, 8'h00);
        cmd(TWCPS_CMD_WRITE, base, 1'b0, 1, 8'h00);
        cmd(TWCPS_CMD_START, 8'h00, 1'b0, 0, 8'h00);
        cmd(TWCPS_CMD_WRITE, SLV | 8'h01, 1'b0, 1, 8'h00);
        for (int i = 0; i < nb; i++) begin
            cmd(TWCPS_CMD_READ, 8'h00, i < nb - 1, 2, shadow[p[4:0]]);
            if (p < TWCPS_REG_TOP) p++;
        end
        cmd(TWCPS_CMD_STOP, 8'h00, 1'b0, 0, 8'h00);
    endtask

    initial begin
        rst_b_in = 1'b0;
        cmd_valid = 1'b0;
        cmd_c = TWCPS_CMD_START;
        wdata = 8'h00;
        ack = 1'b0;
        for (int i = 0; i < 32; i++) begin
            regs[i] = 8'($random(seed));
            shadow[i] = regs[i];
        end
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rst_b_in = 1'b1;
        // straps need a few link clocks to pass the filter
        repeat (10) @(posedge clk_in);
        wr_seq(SLV, 8'h12, 4);
        rd_seq(8'h12, 4);
        for (int i = 0; i < 4; i++) wr_seq({TWCPS_ADDR_HI, 2'(i), 1'b0}, 8'h13, 1);
        wr_seq({TWCPS_ADDR_HI ^ 5'h10, SEL, 1'b0}, 8'h00, 1);
        wr_seq({TWCPS_ADDR_HI, SEL ^ 2'h1, 1'b1}, 8'h00, 0);
        wr_seq(SLV, 8'h15, 1);
        wr_seq(SLV, 8'h00, 2);
        rd_seq(8'h00, 2);
        rd_seq(8'h14, 2);
        rd_seq(8'h13, 1);
        repeat (50) @(posedge clk_in);
        check({selected, 15'(wq.size())}, 16'h0000);
        check(16'(nq.size()), 16'h0000);
        stop_test();
    end
endmodule

/* testbench/twcps_checker.sv */
// line-level assertions for the two-wire link between master and slave ends
`timescale 1ns/10ps
module twcps_checker
    import twcps_pkg::*;
#(
    parameter logic [1:0] SEL = 2'h0
)(
    // clocks and resets
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic link_clk_in,
    input wire logic link_rst_b_in,
    // interface signals
    input wire logic m_scl_out,
    input wire logic m_scl_oe,
    input wire logic m_sda_out,
    input wire logic m_sda_oe,
    input wire logic s_sda_out,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_r, sda_r, rd_r, hit_r, nak_r, rise, go, halt, slot9, match;
    logic [3:0] cnt_r;
    logic [1:0] byte_r;
    logic [7:0] sh_r;

    // line events seen in the master clock, slow scl makes this safe
    assign rise  = scl & ~scl_r;
    assign go    = scl & scl_r & sda_r & ~sda;
    assign halt  = scl & scl_r & ~sda_r & sda;
    assign slot9 = rise & (cnt_r == TWCPS_SLOT_ACK);
    assign match = sh_r[7:1] == {TWCPS_ADDR_HI, SEL};

    // previous line levels
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            scl_r <= scl;
            sda_r <= sda;
        end
    end

    // frame tracker: bit slot, byte index, direction and master nack
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_r  <= 4'h0;
            byte_r <= 2'h3;
            sh_r   <= 8'h00;
            rd_r   <= 1'b0;
            hit_r  <= 1'b0;
            nak_r  <= 1'b0;
        end else if (go | halt) begin
            cnt_r  <= 4'h0;
            byte_r <= go ? 2'h0 : 2'h3;
            nak_r  <= 1'b0;
        end else if (slot9) begin
            cnt_r  <= 4'h0;
            byte_r <= byte_r + {1'b0, byte_r != 2'h3};
            if (byte_r == 2'h0) begin
                hit_r <= match;
                rd_r  <= sh_r[0];
            end
            if (rd_r && hit_r && byte_r != 2'h0 && sda) begin
                nak_r <= 1'b1;
            end
        end else if (rise) begin
            cnt_r <= cnt_r + 4'h1;
            sh_r  <= {sh_r[6:0], sda};
        end
    end

    slave_low_a: assert property (
        @(posedge link_clk_in) disable iff (!link_rst_b_in) s_sda_oe |-> !s_sda_out)
        else $error("slave drove sda high");
    master_low_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) !(m_sda_oe && m_sda_out) && !(m_scl_oe && m_scl_out))
        else $error("master drove a line high");
    sda_stable_a: assert property (
        @(posedge link_clk_in) disable iff (!link_rst_b_in) $changed(s_sda_oe) |-> !scl)
        else $error("slave moved sda while scl high");
    addr_ack_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) slot9 && byte_r == 2'h0 |-> s_sda_oe == match)
        else $error("address acknowledge wrong");
    base_ack_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        slot9 && byte_r == 2'h1 && hit_r && !rd_r |-> s_sda_oe == (sh_r <= TWCPS_REG_TOP))
        else $error("base address acknowledge wrong");
    write_quiet_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        rise && cnt_r != TWCPS_SLOT_ACK && hit_r && !rd_r && byte_r != 2'h0 |-> !s_sda_oe)
        else $error("slave drove a written data bit");
    miss_quiet_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) byte_r != 2'h0 && !hit_r |-> !s_sda_oe)
        else $error("unaddressed slave drove sda");
    nak_release_a: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) nak_r |-> !s_sda_oe)
        else $error("slave kept sending after master nack");
endmodule
